/* File: inc/late_capture_spi_pkg.sv */
/*
  Shared types and constants for the late-capture serial master: the request
  carrier, the pin bundle and the serial timing derived from the link clock.
  Assumes the link clock period below matches the clock fed to clk_link.
*/
`default_nettype none
package late_capture_spi_pkg;

  localparam int unsigned DATA_W                 = 32;
  localparam int unsigned FALLS_W                = 5;
  localparam int unsigned LANES                  = 4;
  localparam int unsigned PIN_IN_W               = 5;
  localparam int unsigned HALF_W                 = 4;

  // Serial clock period limits in ns, and the link clock feeding the engine.
  localparam int unsigned LINK_CLK_PERIOD_NS     = 32;
  localparam int unsigned SYS_CLK_PERIOD_NS      = 5;
  localparam int unsigned SCK_MIN_PERIOD_NS      = 20;
  localparam int unsigned SCK_MAX_PERIOD_NS      = 100;

  // Longest period rounds down to whole link cycles per half, at least one.
  localparam int unsigned SCK_HALF_RAW = SCK_MAX_PERIOD_NS / (2 * LINK_CLK_PERIOD_NS);
  localparam int unsigned SCK_HALF_INT = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;
  localparam logic [HALF_W-1:0] SCK_HALF_RELOAD = HALF_W'(SCK_HALF_INT - 1);

  // Link cycles from the engine's falling edge to the synchronised sample.
  localparam int unsigned CAPTURE_LAG            = 3;

  localparam logic SCK_IDLE                      = 1'b0;
  localparam logic CS_IDLE                       = 1'b1;
  localparam logic [LANES-1:0] SINGLE_OE         = 4'h1;
  localparam logic [DATA_W-1:0] DATA_RESET       = 32'h0000_0000;

  typedef enum logic {PORT_FLASH, PORT_PM} port_e;

  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_TAIL} eng_state_e;

  typedef struct packed {
    port_e               port;
    logic                quad;
    logic                quad_out;
    logic [FALLS_W-1:0]  falls_m1;
    logic [DATA_W-1:0]   tx;
  } xfer_cmd_s;

  typedef struct packed {
    logic               sck;
    logic               cs_n;
    logic [LANES-1:0]   dout;
    logic [LANES-1:0]   oe;
  } pin_out_s;

  localparam xfer_cmd_s CMD_RESET = '{PORT_FLASH, 1'b0, 1'b0, 5'h00, 32'h0000_0000};
  localparam pin_out_s  PINS_IDLE = '{SCK_IDLE, CS_IDLE, 4'h0, 4'h0};

endpackage
`default_nettype wire

/* File: design/spi_shift_engine.sv */
/*
  Serial shift engine on the link clock: chip select, mode-0 clock, launch of the
  first bit with the select fall and each later bit on the falling edge, and delayed capture through the synchroniser.
  Assumes din has already passed two flip-flops on clk_link and that the pin
  registers outside add one cycle to every output alike.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_shift_engine (
  input  wire logic                               clk_link,
  input  wire logic                               rstn,
  input  wire logic                               ce,
  input  wire logic                               start,
  input  wire late_capture_spi_pkg::xfer_cmd_s    cmd,
  input  wire logic [3:0]                         din,
  output var  late_capture_spi_pkg::pin_out_s     pins,
  output logic                                    done,
  output logic [31:0]                             rx_data
);
  import late_capture_spi_pkg::*;

  eng_state_e                st_q;
  eng_state_e                st_d;
  logic [HALF_W-1:0]         half_q;
  logic [FALLS_W-1:0]        falls_q;
  logic [FALLS_W-1:0]        last_q;
  logic [DATA_W-1:0]         tx_q;
  logic [CAPTURE_LAG-1:0]    lag_q;
  logic                      quad_q;

  function automatic logic [LANES-1:0] lead_lanes(input logic [DATA_W-1:0] v,
                                                  input logic q);
    lead_lanes = q ? v[DATA_W-1 -: LANES] : {3'h0, v[DATA_W-1]};
  endfunction

  wire logic              half_tick = (half_q == '0);
  wire logic              fall_now  = (st_q == ST_HIGH) && half_tick;
  wire logic              last_fall = fall_now && (falls_q == last_q);
  wire logic              capture   = lag_q[CAPTURE_LAG-1];
  wire logic              lag_empty = (lag_q == '0);
  wire logic              idle_go   = (st_q == ST_IDLE) && start;
  wire logic [DATA_W-1:0] tx_shift  = quad_q ? {tx_q[DATA_W-5:0], 4'h0}
                                             : {tx_q[DATA_W-2:0], 1'b0};
  // Single-lane replies arrive on lane 1, quad replies on all four lanes.
  wire logic [DATA_W-1:0] rx_shift  = quad_q ? {rx_data[DATA_W-5:0], din}
                                             : {rx_data[DATA_W-2:0], din[1]};

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (start) st_d = ST_LEAD;
      ST_LEAD: if (half_tick) st_d = ST_HIGH;
      ST_HIGH: if (half_tick) st_d = last_fall ? ST_TAIL : ST_LOW;
      ST_LOW:  if (half_tick) st_d = ST_HIGH;
      ST_TAIL: if (lag_empty) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      st_q    <= ST_IDLE;
      half_q  <= SCK_HALF_RELOAD;
      falls_q <= '0;
      last_q  <= '0;
      tx_q    <= DATA_RESET;
      lag_q   <= '0;
      quad_q  <= 1'b0;
      pins    <= PINS_IDLE;
      done    <= 1'b0;
      rx_data <= DATA_RESET;
    end else if (ce) begin
      st_q      <= st_d;
      half_q    <= (half_tick || st_q == ST_IDLE) ? SCK_HALF_RELOAD : half_q - 1'b1;
      pins.sck  <= (st_d == ST_HIGH);
      pins.cs_n <= (st_d == ST_IDLE);
      lag_q     <= {lag_q[CAPTURE_LAG-2:0], fall_now};
      done      <= (st_q == ST_TAIL) && lag_empty;
      if (capture) begin
        rx_data <= rx_shift;
      end
      if (idle_go) begin
        tx_q      <= cmd.tx;
        quad_q    <= cmd.quad;
        last_q    <= cmd.falls_m1;
        falls_q   <= '0;
        rx_data   <= DATA_RESET;
        pins.dout <= lead_lanes(cmd.tx, cmd.quad);
        pins.oe   <= cmd.quad ? {LANES{cmd.quad_out}} : SINGLE_OE;
      end else if (fall_now) begin
        tx_q      <= tx_shift;
        falls_q   <= falls_q + 1'b1;
        pins.dout <= lead_lanes(tx_shift, quad_q);
      end else if (st_d == ST_IDLE) begin
        pins.oe   <= '0;
      end
    end
  end

endmodule // spi_shift_engine
`default_nettype wire

/* File: design/late_capture_spi_master.sv */
/*
  Serial master for the boot flash port and the power-management port.
  Requests arrive on clk_sys and are handed to the shift engine on clk_link
  by a toggle handshake; the reply word returns the same way.
  Assumes clk_link runs free and that an outside wire resolves the flash
  data lines from the output enables.
*/
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Flash port: master, mode 0, clock idles low.
// - Sample flash input on the launching falling edge.
// - Flash clock period between 20 and 100 ns.
// - Flash bits launch on falls or select fall.
// - Four flash data lines, each two-way.
// - Power port: master, mode 0, late capture.
// - Power bits launch on falls or select fall.
// - Power clock period at most 100 ns.
module late_capture_spi_master (
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  input  wire logic                               ce,
  input  wire logic                               clk_link,
  input  wire logic                               req_valid,
  input  wire late_capture_spi_pkg::xfer_cmd_s    req,
  output logic                                    req_ready,
  output logic                                    resp_valid,
  output logic [31:0]                             resp_data,
  output logic                                    flash_serial_clock,
  output logic                                    flash_chip_select_n,
  output logic [3:0]                              flash_data_lines_out,
  output logic [3:0]                              flash_data_lines_oe,
  input  wire logic [3:0]                         flash_data_lines_in,
  output logic                                    pm_serial_clock,
  output logic                                    pm_chip_select0_n,
  output logic                                    pm_data_out,
  input  wire logic                               pm_data_in
);
  import late_capture_spi_pkg::*;

  // System clock side.
  xfer_cmd_s              cmd_q;
  logic                   busy_q;
  logic                   req_tgl_q;
  logic                   ack_s1_q;
  logic                   ack_s2_q;
  logic                   ack_s3_q;

  // Link clock side.
  logic                   ce_s1_q;
  logic                   ce_link_q;
  logic                   req_s1_q;
  logic                   req_s2_q;
  logic                   req_s3_q;
  logic                   ack_tgl_q;
  port_e                  port_q;
  logic [PIN_IN_W-1:0]    din_s1_q;
  logic [PIN_IN_W-1:0]    din_s2_q;

  pin_out_s               eng_pins;
  logic                   eng_done;
  logic [DATA_W-1:0]      eng_rx;

  wire logic                accept    = req_valid && req_ready;
  wire logic                ack_evt   = ack_s2_q ^ ack_s3_q;
  wire logic                start     = req_s2_q ^ req_s3_q;
  wire logic [PIN_IN_W-1:0] din_raw   = {pm_data_in, flash_data_lines_in};
  wire logic                sel_pm    = (port_q == PORT_PM);
  wire logic [LANES-1:0]    eng_din   = sel_pm ? {2'h0, din_s2_q[PIN_IN_W-1], 1'b0}
                                             : din_s2_q[LANES-1:0];
  wire logic                fl_sck    = !sel_pm && eng_pins.sck;
  wire logic                fl_cs_n   = sel_pm || eng_pins.cs_n;
  wire logic [LANES-1:0]    fl_oe     = sel_pm ? 4'h0 : eng_pins.oe;
  wire logic                pm_sck    = sel_pm && eng_pins.sck;
  wire logic                pm_cs_n   = !sel_pm || eng_pins.cs_n;

  // Only one transfer is in flight, so cmd_q stays still while the link side
  // reads it and eng_rx stays still while the system side copies it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_q      <= CMD_RESET;
      busy_q     <= 1'b0;
      req_tgl_q  <= 1'b0;
      req_ready  <= 1'b0;
      resp_valid <= 1'b0;
      resp_data  <= DATA_RESET;
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
      ack_s3_q   <= 1'b0;
    end else if (ce) begin
      ack_s1_q   <= ack_tgl_q;
      ack_s2_q   <= ack_s1_q;
      ack_s3_q   <= ack_s2_q;
      resp_valid <= ack_evt;
      req_ready  <= !busy_q && !accept;
      if (accept) begin
        cmd_q     <= req;
        busy_q    <= 1'b1;
        req_tgl_q <= !req_tgl_q;
      end else if (ack_evt) begin
        busy_q    <= 1'b0;
        resp_data <= eng_rx;
      end
    end
  end

  // The enable is carried into the link domain through two flip-flops, so the link side freezes two link cycles after the system side.
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      ce_s1_q   <= 1'b0;
      ce_link_q <= 1'b0;
    end else begin
      ce_s1_q   <= ce;
      ce_link_q <= ce_s1_q;
    end
  end

  for (genvar i = 0; i < PIN_IN_W; i++) begin : g_pin_sync
    always_ff @(posedge clk_link or negedge rstn) begin
      if (!rstn) begin
        din_s1_q[i] <= 1'b0;
        din_s2_q[i] <= 1'b0;
      end else if (ce_link_q) begin
        din_s1_q[i] <= din_raw[i];
        din_s2_q[i] <= din_s1_q[i];
      end
    end
  end

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      req_s3_q  <= 1'b0;
      ack_tgl_q <= 1'b0;
      port_q    <= PORT_FLASH;
    end else if (ce_link_q) begin
      req_s1_q  <= req_tgl_q;
      req_s2_q  <= req_s1_q;
      req_s3_q  <= req_s2_q;
      if (start) begin
        port_q    <= cmd_q.port;
      end
      if (eng_done) begin
        ack_tgl_q <= !ack_tgl_q;
      end
    end
  end

  // Pins are registered once more so each output leaves from a flip-flop;
  // the capture lag in the engine already counts this stage.
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      flash_serial_clock   <= SCK_IDLE;
      flash_chip_select_n  <= CS_IDLE;
      flash_data_lines_out <= 4'h0;
      flash_data_lines_oe  <= 4'h0;
      pm_serial_clock      <= SCK_IDLE;
      pm_chip_select0_n    <= CS_IDLE;
      pm_data_out          <= 1'b0;
    end else if (ce_link_q) begin
      flash_serial_clock   <= fl_sck;
      flash_chip_select_n  <= fl_cs_n;
      flash_data_lines_out <= eng_pins.dout;
      flash_data_lines_oe  <= fl_oe;
      pm_serial_clock      <= pm_sck;
      pm_chip_select0_n    <= pm_cs_n;
      pm_data_out          <= eng_pins.dout[0];
    end
  end

  spi_shift_engine u_engine (
    .clk_link (clk_link),
    .rstn     (rstn),
    .ce       (ce_link_q),
    .start    (start),
    .cmd      (cmd_q),
    .din      (eng_din),
    .pins     (eng_pins),
    .done     (eng_done),
    .rx_data  (eng_rx)
  );

endmodule // late_capture_spi_master
`default_nettype wire

/* File: verif/late_capture_spi_master_assertions.sv */
/*
  Pin checker for the late-capture serial master, bound to its top module.
  Assumes every serial pin is registered on clk_link.
*/
`timescale 1ns/100ps
`default_nettype none
module late_capture_spi_master_assertions (
  input wire logic       clk_link,
  input wire logic       rstn,
  input wire logic       flash_serial_clock,
  input wire logic       flash_chip_select_n,
  input wire logic [3:0] flash_data_lines_out,
  input wire logic [3:0] flash_data_lines_oe,
  input wire logic       pm_serial_clock,
  input wire logic       pm_chip_select0_n,
  input wire logic       pm_data_out
);
  default clocking @(posedge clk_link); endclocking
  default disable iff (!rstn);
  flash_idle_low_a: assert property (
    flash_chip_select_n |-> !flash_serial_clock) else $error("flash clock high while idle");
  flash_half_period_a: assert property (
    $rose(flash_serial_clock) |=> $fell(flash_serial_clock)) else $error("flash high phase");
  flash_launch_edge_a: assert property (
    !flash_chip_select_n && !$past(flash_chip_select_n) && !$stable(flash_data_lines_out)
    |-> $fell(flash_serial_clock)) else $error("flash data moved off a falling edge");
  flash_lane_drive_a: assert property (
    flash_data_lines_oe inside {4'h0, 4'h1, 4'hf}
    && (!flash_chip_select_n || flash_data_lines_oe == 4'h0)) else $error("flash enables");
  flash_late_release_a: assert property (
    $rose(flash_chip_select_n) |-> !$past(flash_serial_clock, 1) && !$past(flash_serial_clock, 2)
    && !$past(flash_serial_clock, 3)) else $error("flash select released early");
  pm_idle_low_a: assert property (
    pm_chip_select0_n |-> !pm_serial_clock) else $error("pm clock high while idle");
  pm_half_period_a: assert property (
    $rose(pm_serial_clock) |=> $fell(pm_serial_clock)) else $error("pm high phase");
  pm_launch_edge_a: assert property (
    !pm_chip_select0_n && !$past(pm_chip_select0_n) && !$stable(pm_data_out)
    |-> $fell(pm_serial_clock)) else $error("pm data moved off a falling edge");
  pm_late_release_a: assert property (
    $rose(pm_chip_select0_n) |-> !$past(pm_serial_clock, 1) && !$past(pm_serial_clock, 2)
    && !$past(pm_serial_clock, 3)) else $error("pm select released early");
endmodule // late_capture_spi_master_assertions
bind late_capture_spi_master late_capture_spi_master_assertions u_chk (
  .clk_link(clk_link), .rstn(rstn), .flash_serial_clock(flash_serial_clock),
  .flash_chip_select_n(flash_chip_select_n), .flash_data_lines_out(flash_data_lines_out),
  .flash_data_lines_oe(flash_data_lines_oe), .pm_serial_clock(pm_serial_clock),
  .pm_chip_select0_n(pm_chip_select0_n), .pm_data_out(pm_data_out));
`default_nettype wire

/* File: verif/spi_far_side_model.sv */
/*
  Far-side serial peripheral: flash or power controller answering a mode-0 master.
  Assumes the master samples each returned bit on the next falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_far_side_model (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        quad,
  input  wire logic [3:0]  mosi,
  input  wire logic [31:0] reply,
  output logic [3:0]       miso,
  output logic [31:0]      got
);
  logic [31:0] sh_q;
  initial miso = 4'h0;
  initial got = 32'h0;
  always @(negedge cs_n) begin
    sh_q = reply;
    got = 32'h0;
    miso = quad ? sh_q[31:28] : {4{sh_q[31]}};
  end
  // Each bit stands until the next fall, so the master's late sample still sees it.
  always @(negedge sck) if (!cs_n) begin
    sh_q = quad ? sh_q << 4 : sh_q << 1;
    miso = quad ? sh_q[31:28] : {4{sh_q[31]}};
  end
  always @(posedge sck) got = quad ? {got[27:0], mosi} : {got[30:0], mosi[0]};
  // Released lines show the inverse, so a stale sample cannot pass as data.
  always @(posedge cs_n) miso = ~miso;
endmodule // spi_far_side_model
`default_nettype wire

/* File: verif/tb_top.sv */
/*
  Self-checking bench for the late-capture serial master with both far-side parts.
  Assumes one request at a time and resolves the flash lines from the enables.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import late_capture_spi_pkg::*;
  logic        clk_sys = 1'b0, clk_link = 1'b0, rstn = 1'b0, req_valid = 1'b0, f_quad = 1'b0;
  xfer_cmd_s   req = CMD_RESET;
  logic        req_ready, resp_valid, fsck, fcs_n, psck, pcs_n, pdo;
  logic [31:0] resp_data, f_got, p_got, reply = 32'h0;
  logic [3:0]  f_out, f_oe, f_miso, p_miso, f_wire;
  int          n_mismatch = 0, check_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  initial #3.3 forever #16 clk_link = ~clk_link;
  assign f_wire = (f_oe & f_out) | (~f_oe & f_miso);
  late_capture_spi_master u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .clk_link(clk_link),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .flash_serial_clock(fsck), .flash_chip_select_n(fcs_n),
    .flash_data_lines_out(f_out), .flash_data_lines_oe(f_oe), .flash_data_lines_in(f_wire),
    .pm_serial_clock(psck), .pm_chip_select0_n(pcs_n), .pm_data_out(pdo), .pm_data_in(p_miso[0]));
  spi_far_side_model u_flash (.sck(fsck), .cs_n(fcs_n), .quad(f_quad), .mosi(f_wire),
    .reply(reply), .miso(f_miso), .got(f_got));
  spi_far_side_model u_pm (.sck(psck), .cs_n(pcs_n), .quad(1'b0), .mosi({3'h0, pdo}),
    .reply(reply), .miso(p_miso), .got(p_got));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Entered just after a clk_sys edge; the next request follows the reply at once.
  task automatic xfer(input port_e p, input logic q, input logic qo, input int n,
                      input logic [31:0] tx, input logic [31:0] rp);
    int t;
    int b;
    b = q ? 4 * n : n;
    reply = rp;
    f_quad = q;
    req = '{p, q, qo, 5'(n - 1), tx};
    req_valid = 1'b1;
    for (t = 0; t < 100 && req_ready !== 1'b1; t++) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    for (t = 0; t < 3000 && resp_valid !== 1'b1; t++) @(posedge clk_sys) #1;
    if (qo !== 1'b1) chk("reply word", rp >> (32 - b), resp_data);
    if (q !== 1'b1 || qo === 1'b1) chk("sent word", tx >> (32 - b), p == PORT_PM ? p_got : f_got);
  endtask
  task automatic s_flash_single();
    xfer(PORT_FLASH, 1'b0, 1'b0, 8, 32'ha500_0000, 32'h3c00_0000);
    xfer(PORT_FLASH, 1'b0, 1'b0, 32, 32'h8123_4567, 32'hfedc_ba91);
  endtask
  task automatic s_flash_quad();
    xfer(PORT_FLASH, 1'b1, 1'b0, 2, 32'h0000_0000, 32'h9600_0000);
    xfer(PORT_FLASH, 1'b1, 1'b1, 3, 32'h5a3c_0000, 32'h0000_0000);
  endtask
  task automatic s_pm();
    xfer(PORT_PM, 1'b0, 1'b0, 1, 32'h8000_0000, 32'h8000_0000);
    xfer(PORT_PM, 1'b0, 1'b0, 16, 32'hc3a5_0000, 32'h6e81_0000);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    repeat (2) @(posedge clk_link);
    @(posedge clk_sys) #1;
    rstn = 1'b1;
    @(posedge clk_sys) #1;
    s_flash_single();
    s_flash_quad();
    s_pm();
    wrap_up();
  end
  // Six transfers need well under 20 us; five times that marks a hang.
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
